// ==== bench/dsp_operand_address_decode_bench.sv ====
// Self-checking bench for the operand address decoder.
`timescale 1ns/10ps
module dsp_operand_address_decode_bench;
  reg i_core_clk = 0, i_arst_n = 0, i_instr_valid = 0, i_avs_read = 0, i_avs_write = 0;
  reg [15:0] i_instr = 16'h0000, i_port_data = 16'h0000, i_mult_in = 16'h0000;
  reg [2:0] i_avs_address = 3'h0;
  reg [31:0] i_avs_writedata = 32'h0;
  reg [3:0] i_avs_byteenable = 4'hf;
  wire [15:0] i_dmem_rdata, o_dmem_wdata;
  wire [7:0] o_dmem_addr;
  wire [31:0] o_acc_value, o_product, o_avs_readdata;
  wire [3:0] o_shift_cnt;
  wire [2:0] o_port_addr;
  wire o_instr_ready, o_dmem_rd, o_dmem_wr, o_port_rd, o_tbl_rd, o_tbl_wr, o_shift_valid;
  wire o_acc_load, o_product_valid, o_page_select_bit, o_aux_select_pointer, o_avs_waitrequest;
  integer fail_count = 0, checked = 0;
  // Expected operand addresses, oldest first.
  reg [7:0] q[$];
  reg [7:0] k0, k1;
  reg [31:0] d, w;
  dspoad_decode dut (.i_core_clk, .i_arst_n, .i_instr, .i_instr_valid, .o_instr_ready, .i_dmem_rdata,
    .i_port_data, .i_mult_in, .o_dmem_addr, .o_dmem_rd, .o_dmem_wr, .o_dmem_wdata, .o_port_rd, .o_port_addr,
    .o_tbl_rd, .o_tbl_wr, .o_shift_cnt, .o_shift_valid, .o_acc_load, .o_acc_value, .o_product,
    .o_product_valid, .o_page_select_bit, .o_aux_select_pointer, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest);
  dspoad_mem_model mem (.i_core_clk, .i_rd(o_dmem_rd), .i_wr(o_dmem_wr), .i_addr(o_dmem_addr),
    .i_wdata(o_dmem_wdata), .o_rdata(i_dmem_rdata));
  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // Prints the counts and the verdict, then stops.
  task conclude;
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One comparison, counted.
  task automatic chk(input [31:0] g, input [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Offers one instruction and returns at the edge that takes it; valid stays up for back to back use.
  task automatic iss(input [15:0] v);
    integer t;
    i_instr <= v;
    i_instr_valid <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge i_core_clk);
      if (o_instr_ready === 1'b1) break;
    end
    if (t == 50) begin
      fail_count++;
      $display("mismatch at %0t: instruction never taken", $time);
      conclude();
    end
  endtask
  // One bus cycle; the request is held until waitrequest is seen low at an edge.
  task automatic avs(input bit wr, input [2:0] a, input [31:0] wd, output [31:0] rd);
    integer t;
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= wd;
    for (t = 0; t < 50; t++) begin
      @(posedge i_core_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_core_clk);
    if (t == 50) begin
      fail_count++;
      $display("mismatch at %0t: bus never answered", $time);
      conclude();
    end
  endtask
  // Every operand read must match the oldest expected address; an unexpected read meets an unknown.
  always @(posedge i_core_clk) begin
    if (i_arst_n && o_dmem_rd === 1'b1) begin
      chk({24'h0, o_dmem_addr}, {24'h0, (q.size() > 0) ? q.pop_front() : 8'hxx});
    end
  end
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    void'($urandom(49522));
    k0 = $urandom;
    k1 = $urandom;
    w = $urandom;
    i_mult_in <= $urandom;
    i_port_data <= $urandom;
    // The page bit is set before any direct access, since reset leaves it unknown.
    iss(16'h6e01);
    q.push_back(8'h92);
    iss(16'h0512);
    iss({8'h70, k0});
    iss({8'h71, k1});
    iss(16'h6900);
    // Indirect words keep their reserved bits clear.
    q.push_back(k0);
    iss(16'h08a8);
    q.push_back(k0 + 8'h01);
    iss(16'h0891);
    q.push_back(k1);
    iss(16'h0888);
    // Memory load into register one, used at once through the pointer.
    q.push_back(8'h85);
    iss(16'h3905);
    q.push_back(8'h85);
    iss(16'h0888);
    // A memory multiply directly followed by an immediate one.
    q.push_back(8'h85);
    iss(16'h6d05);
    iss({3'h4, w[12:0]});
    iss({8'h7e, k1});
    iss(16'h4312);
    iss(16'hf000);
    iss(16'h7f00);
    iss(16'h6712);
    iss(16'h7d12);
    i_instr_valid <= 1'b0;
    avs(1'b0, 3'h1, 32'h0, d);
    chk(d, 32'h3);
    avs(1'b0, 3'h2, 32'h0, d);
    chk(d[7:0], k0);
    avs(1'b0, 3'h3, 32'h0, d);
    chk(d, 32'h00008585);
    chk(mem.mem[8'h92], i_port_data);
    avs(1'b0, 3'h5, 32'h0, d);
    chk(d, 32'h0);
    avs(1'b1, 3'h0, 32'h0, d);
    chk(o_instr_ready, 1'b0);
    avs(1'b1, 3'h0, 32'h1, d);
    chk(o_instr_ready, 1'b1);
    chk(q.size(), 0);
    conclude();
  end
endmodule // dsp_operand_address_decode_bench

// ==== bench/dspoad_decode_sva.sv ====
// Concurrent checks on the ports of the operand address decoder.
`timescale 1ns/10ps
module dspoad_chk (
  input wire i_core_clk,
  input wire i_arst_n,
  input wire [15:0] i_instr,
  input wire i_instr_valid,
  input wire o_instr_ready,
  input wire [15:0] i_mult_in,
  input wire [7:0] o_dmem_addr,
  input wire o_dmem_rd,
  input wire o_dmem_wr,
  input wire o_port_rd,
  input wire [2:0] o_port_addr,
  input wire o_tbl_rd,
  input wire o_tbl_wr,
  input wire [3:0] o_shift_cnt,
  input wire o_shift_valid,
  input wire o_acc_load,
  input wire [31:0] o_acc_value,
  input wire [31:0] o_product,
  input wire o_product_valid,
  input wire o_page_select_bit,
  input wire o_aux_select_pointer
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  // An instruction is taken at an edge with valid and ready both high.
  wire take = i_instr_valid & o_instr_ready;
  wire [7:0] op = i_instr[15:8];
  wire add_t = take & (op[7:4] == 4'h0);
  // Expected product of the sign-extended short constant.
  wire signed [31:0] prod_w = $signed({{3{i_instr[12]}}, i_instr[12:0]}) * $signed(i_mult_in);
  property p_direct;
    add_t && !i_instr[7] |=> o_dmem_rd && o_dmem_addr == {o_page_select_bit, $past(i_instr[6:0])};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_shift;
    add_t |=> o_shift_valid && o_shift_cnt == $past(i_instr[11:8]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift count wrong");
  property p_acc_short;
    take && op == 8'h7e |=> o_acc_load && o_acc_value == {24'h000000, $past(i_instr[7:0])};
  endproperty
  a_acc_short: assert property (p_acc_short) else $error("short load wrong");
  property p_mul_imm;
    take && op[7:5] == 3'h4 |=> o_product_valid && o_product == $past(prod_w);
  endproperty
  a_mul_imm: assert property (p_mul_imm) else $error("immediate product wrong");
  property p_in;
    take && op[7:3] == 5'h08 |=> o_port_rd && !o_instr_ready ##1 o_dmem_wr && o_instr_ready;
  endproperty
  a_in: assert property (p_in) else $error("port input timing wrong");
  property p_port_addr;
    take && op[7:3] == 5'h08 |=> o_port_addr == $past(op[2:0]);
  endproperty
  a_port_addr: assert property (p_port_addr) else $error("port address wrong");
  property p_tab_rd;
    take && op == 8'h67 |=> o_tbl_rd && !o_tbl_wr && !o_dmem_rd;
  endproperty
  a_tab_rd: assert property (p_tab_rd) else $error("table read strobe wrong");
  property p_tab_wr;
    take && op == 8'h7d |=> o_tbl_wr && !o_tbl_rd && !o_dmem_wr;
  endproperty
  a_tab_wr: assert property (p_tab_wr) else $error("table write strobe wrong");
  property p_reload;
    add_t && i_instr[7] && !i_instr[3] |=> o_aux_select_pointer == $past(i_instr[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("pointer not reloaded");
  property p_keep;
    add_t && i_instr[7] && i_instr[3] |=> $stable(o_aux_select_pointer);
  endproperty
  a_keep: assert property (p_keep) else $error("pointer changed");
  property p_page;
    $changed(o_page_select_bit) |-> $past(take && op == 8'h6e) || $past(take && (op == 8'h6f || op == 8'h7b), 2);
  endproperty
  a_page: assert property (p_page) else $error("page bit changed without load");
  property p_noopnd;
    take && (op[7:4] == 4'hf || op == 8'h7f) |=> !o_dmem_rd && !o_dmem_wr;
  endproperty
  a_noopnd: assert property (p_noopnd) else $error("operand access without operand");
endmodule // dspoad_chk
bind dspoad_decode dspoad_chk u_chk (.i_core_clk, .i_arst_n, .i_instr, .i_instr_valid, .o_instr_ready,
  .i_mult_in, .o_dmem_addr, .o_dmem_rd, .o_dmem_wr, .o_port_rd, .o_port_addr, .o_tbl_rd, .o_tbl_wr,
  .o_shift_cnt, .o_shift_valid, .o_acc_load,
  .o_acc_value, .o_product, .o_product_valid, .o_page_select_bit, .o_aux_select_pointer);

// ==== bench/dspoad_mem_model.sv ====
// Data memory model standing beside the operand address decoder.
`timescale 1ns/10ps
module dspoad_mem_model (
  input wire i_core_clk,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  output wire [15:0] o_rdata
);
  // Storage, preset to a pattern that differs at every address.
  reg [15:0] mem [0:255];
  // Last word shown, so the idle bus can show its inverse.
  reg [15:0] last = 16'h0000;
  integer n;
  initial begin
    for (n = 0; n < 256; n = n + 1) mem[n] = 16'(n * 16'h0101);
  end
  // Writes land at the edge; reads are remembered for the idle pattern.
  always @(posedge i_core_clk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    if (i_rd) last <= mem[i_addr];
  end
  // The word stands only in the read cycle; otherwise the bus shows stale inverted data.
  assign o_rdata = i_rd ? mem[i_addr] : ~last;
endmodule // dspoad_mem_model

// ==== rtl/dspoad_aux_regs.v ====
// Two auxiliary registers with load, post-step and forwarding.
`timescale 1ns/10ps
module dspoad_aux_regs (
  input wire i_core_clk,
  input wire i_arst_n,
  input wire [1:0] i_load_en,
  input wire [31:0] i_load_data,
  input wire [1:0] i_inc,
  input wire [1:0] i_dec,
  output wire [31:0] o_aux_stored,
  output wire [31:0] o_aux_eff
);
  genvar gi;
  // One slice per auxiliary register.
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_aux
      reg [15:0] aux_reg; // Stored register value.
      wire [15:0] base; // Value after any load landing this cycle.
      wire [15:0] aux_next;
      assign base = i_load_en[gi] ? i_load_data[16*gi +: 16] : aux_reg;
      // Both step bits set cancel out, leaving the value unchanged.
      assign aux_next = (i_inc[gi] && !i_dec[gi]) ? base + 16'h0001 :
                        (i_dec[gi] && !i_inc[gi]) ? base - 16'h0001 : base;
      // Update lands at the edge that retires the instruction.
      always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          aux_reg <= 16'h0000;
        end else begin
          aux_reg <= aux_next;
        end
      end
      assign o_aux_stored[16*gi +: 16] = aux_reg;
      // The forwarded value lets the next instruction see a load at once.
      assign o_aux_eff[16*gi +: 16] = base;
    end
  endgenerate
endmodule // dspoad_aux_regs

// ==== rtl/dspoad_consts.vh ====
// Constants shared by the operand address decoder and its helpers.
`ifndef DSPOAD_CONSTS_VH
`define DSPOAD_CONSTS_VH
// Instruction word field positions.
`define DSPOAD_MODE_BIT 7
`define DSPOAD_INC_BIT 5
`define DSPOAD_DEC_BIT 4
`define DSPOAD_RELOAD_BIT 3
`define DSPOAD_ARSEL_BIT 0
// Opcodes, full upper byte.
`define DSPOAD_OP_ACC_SHORT 8'h7e
`define DSPOAD_OP_PTR_IMM 8'h69
`define DSPOAD_OP_MODIFY 8'h68
`define DSPOAD_OP_PAGE_IMM 8'h6e
`define DSPOAD_OP_PAGE_MEM 8'h6f
`define DSPOAD_OP_STATUS_LD 8'h7b
`define DSPOAD_OP_MUL_MEM 8'h6d
`define DSPOAD_OP_TAB_RD 8'h67
`define DSPOAD_OP_TAB_WR 8'h7d
`define DSPOAD_OP_NOOPND 8'h7f
// Opcode prefixes; the bit below an aux prefix selects a register, the three bits below the input prefix a port.
`define DSPOAD_PFX_AUX_IMM 7'h38
`define DSPOAD_PFX_AUX_MEM 7'h1c
`define DSPOAD_PFX_AUX_ST 7'h18
`define DSPOAD_PFX_IN 5'h08
`define DSPOAD_PFX_ADD 4'h0
`define DSPOAD_PFX_BRANCH 4'hf
`define DSPOAD_PFX_MUL_IMM 3'h4
// Status word layout as restored from memory by the status load.
`define DSPOAD_STAT_PAGE 0
`define DSPOAD_STAT_PTR 1
// Register word indexes on the Avalon slave.
`define DSPOAD_REG_CTRL 3'h0
`define DSPOAD_REG_STATUS 3'h1
`define DSPOAD_REG_AUX0 3'h2
`define DSPOAD_REG_AUX1 3'h3
`define DSPOAD_REG_LASTADDR 3'h4
// Reset value of the control register: decoding enabled.
`define DSPOAD_CTRL_RST 1'h1
`endif

// ==== rtl/dspoad_decode.v ====
// Operand addressing decoder: direct, indirect and immediate modes.
//
// How it works
// - Direct address is page bit over field.
// - Bit seven picks direct or indirect.
// - Opcode upper byte, address low seven bits.
// - Only three instructions write page bit.
// - Reset leaves page bit untouched.
// - No direct address for branch, immediate, operandless.
// - Indirect address is selected aux low byte.
// - Pointer value picks aux zero or one.
// - Bit three clear reloads pointer from bit0.
// - Bit five increments, bit four decrements.
// - Aux step after use, no extra cycle.
// - Aux load, immediate load, modify, store.
// - Five immediates finish in one cycle.
// - Immediate multiply fills product register.
// - Short accumulator load zeroes upper bits.
// - Add shift count from bits 11:8.
// - Port input takes two cycles.
// - Table read and write bridge spaces.
// - Page holds 128 words, field indexes it.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "dspoad_consts.vh"
module dspoad_decode (
  input wire i_core_clk,
  input wire i_arst_n,
  input wire [15:0] i_instr,
  input wire i_instr_valid,
  output wire o_instr_ready,
  input wire [15:0] i_dmem_rdata,
  input wire [15:0] i_port_data,
  input wire [15:0] i_mult_in,
  output reg [7:0] o_dmem_addr,
  output reg o_dmem_rd,
  output reg o_dmem_wr,
  output reg [15:0] o_dmem_wdata,
  output reg o_port_rd,
  output reg [2:0] o_port_addr,
  output reg o_tbl_rd,
  output reg o_tbl_wr,
  output reg [3:0] o_shift_cnt,
  output reg o_shift_valid,
  output reg o_acc_load,
  output reg [31:0] o_acc_value,
  output wire [31:0] o_product,
  output wire o_product_valid,
  output wire o_page_select_bit,
  output wire o_aux_select_pointer,
  input wire [2:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest
);
  // One-hot sequencer states; the second state finishes a port input.
  localparam ST_RUN = 2'b01;
  localparam ST_IN2 = 2'b10;

  reg [1:0] state_reg; // Sequencer state.
  reg [1:0] state_next;
  reg page_select_bit_reg; // Page bit, deliberately without reset.
  reg aux_select_pointer_reg; // Selects the current auxiliary register.
  reg ctrl_en_reg; // Software enable for instruction decoding.
  reg ack_reg; // Avalon answer phase.
  // Loads waiting for memory read data, one cycle after the address.
  reg pend_page_reg; // Page load from memory lands next edge.
  reg pend_status_reg; // Status word load lands next edge.
  reg [1:0] pend_aux_reg; // Auxiliary load per register.
  reg pend_mul_reg; // Memory multiply operand arrives next edge.
  reg [7:0] last_addr_reg; // Last data address issued, for software.

  wire take; // An instruction is accepted this edge.
  wire [7:0] opc; // Operation code field.
  wire indirect; // Addressing mode bit.
  wire is_acc_short, is_aux_imm, is_ptr_imm, is_page_imm, is_mul_imm;
  wire is_imm, is_branch, is_noopnd, has_operand;
  wire is_page_mem, is_status_ld, is_aux_mem, is_aux_st, is_modify, is_mul_mem, is_in, is_add;
  wire is_tab_rd, is_tab_wr;
  wire eff_page; // Page bit including a load landing this cycle.
  wire eff_ptr; // Pointer including a status load landing now.
  wire [31:0] aux_stored;
  wire [31:0] aux_eff;
  wire [15:0] aux_cur; // Current auxiliary register, forwarded.
  wire [7:0] operand_addr;
  wire aux_step; // Indirect field modifies the current register.
  wire [1:0] aux_imm_hit; // Immediate auxiliary load, one bit per register.
  wire [1:0] load_en;
  wire [31:0] load_data;
  wire [1:0] step_inc;
  wire [1:0] step_dec;
  wire avs_req;

  // Requests are refused while disabled or finishing a port input.
  assign o_instr_ready = ctrl_en_reg && state_reg[0];
  assign take = i_instr_valid && o_instr_ready;

  assign opc = i_instr[15:8];
  assign indirect = i_instr[`DSPOAD_MODE_BIT];

  // Instruction classes; prefix compares leave out register, port, shift-count, branch or constant bits.
  // Decoding is flat and combinational so every class is known in the
  // cycle the word is offered, which keeps the issue stage single-cycle.
  assign is_acc_short = (opc == `DSPOAD_OP_ACC_SHORT);
  assign is_aux_imm = (opc[7:1] == `DSPOAD_PFX_AUX_IMM);
  assign is_ptr_imm = (opc == `DSPOAD_OP_PTR_IMM);
  assign is_page_imm = (opc == `DSPOAD_OP_PAGE_IMM);
  assign is_mul_imm = (opc[7:5] == `DSPOAD_PFX_MUL_IMM);
  assign is_imm = is_acc_short || is_aux_imm || is_ptr_imm || is_page_imm || is_mul_imm;
  assign is_branch = (opc[7:4] == `DSPOAD_PFX_BRANCH);
  assign is_noopnd = (opc == `DSPOAD_OP_NOOPND);
  assign has_operand = !(is_imm || is_branch || is_noopnd);
  assign is_page_mem = (opc == `DSPOAD_OP_PAGE_MEM);
  assign is_status_ld = (opc == `DSPOAD_OP_STATUS_LD);
  assign is_aux_mem = (opc[7:1] == `DSPOAD_PFX_AUX_MEM);
  assign is_aux_st = (opc[7:1] == `DSPOAD_PFX_AUX_ST);
  assign is_modify = (opc == `DSPOAD_OP_MODIFY);
  assign is_mul_mem = (opc == `DSPOAD_OP_MUL_MEM);
  assign is_in = (opc[7:3] == `DSPOAD_PFX_IN);
  assign is_add = (opc[7:4] == `DSPOAD_PFX_ADD);
  assign is_tab_rd = (opc == `DSPOAD_OP_TAB_RD);
  assign is_tab_wr = (opc == `DSPOAD_OP_TAB_WR);

  // forward pending loads
  // Forwarding the landing word avoids a stall after a memory load.
  assign eff_page = (pend_page_reg || pend_status_reg) ?
                    i_dmem_rdata[`DSPOAD_STAT_PAGE] : page_select_bit_reg;
  assign eff_ptr = pend_status_reg ? i_dmem_rdata[`DSPOAD_STAT_PTR] : aux_select_pointer_reg;

  assign aux_cur = eff_ptr ? aux_eff[31:16] : aux_eff[15:0];

  assign operand_addr = indirect ? aux_cur[7:0] : {eff_page, i_instr[6:0]};

  assign aux_imm_hit[0] = take && is_aux_imm && !opc[0];
  assign aux_imm_hit[1] = take && is_aux_imm && opc[0];

  // Per-register load sources; an immediate and a memory load may land
  // together on different registers, so each register has its own data.
  // On one register the immediate is younger and therefore wins.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_load
      assign load_en[gi] = aux_imm_hit[gi] || pend_aux_reg[gi];
      assign load_data[16*gi +: 16] = aux_imm_hit[gi] ? {8'h00, i_instr[7:0]} : i_dmem_rdata;
      assign step_inc[gi] = aux_step && (eff_ptr == gi) && i_instr[`DSPOAD_INC_BIT];
      assign step_dec[gi] = aux_step && (eff_ptr == gi) && i_instr[`DSPOAD_DEC_BIT];
    end
  endgenerate

  assign aux_step = take && indirect && has_operand;

  // The step is applied at the same edge that issues the old address.
  dspoad_aux_regs u_aux (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_load_en(load_en),
    .i_load_data(load_data),
    .i_inc(step_inc),
    .i_dec(step_dec),
    .o_aux_stored(aux_stored),
    .o_aux_eff(aux_eff)
  );

  dspoad_mul u_mul (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_start((take && is_mul_imm) || pend_mul_reg),
    // A younger immediate multiply overwrites a memory multiply landing now.
    .i_operand((take && is_mul_imm) ? {{3{i_instr[12]}}, i_instr[12:0]} : i_dmem_rdata),
    .i_mult_in(i_mult_in),
    .o_product(o_product),
    .o_product_valid(o_product_valid)
  );

  // no reset on page
  // Program order wins: a page immediate beats a load still landing.
  // Leaving it unreset means software must load it before direct access.
  always @(posedge i_core_clk) begin
    if (take && is_page_imm) begin
      page_select_bit_reg <= i_instr[0];
    end else if (pend_page_reg || pend_status_reg) begin
      page_select_bit_reg <= i_dmem_rdata[`DSPOAD_STAT_PAGE];
    end
  end

  // pointer reload control
  // The current instruction is younger than a landing status load.
  // A kept pointer still takes the older status load landing now.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aux_select_pointer_reg <= 1'b0;
    end else if (take && is_ptr_imm) begin
      aux_select_pointer_reg <= i_instr[0];
    end else if (aux_step && !i_instr[`DSPOAD_RELOAD_BIT]) begin
      aux_select_pointer_reg <= i_instr[`DSPOAD_ARSEL_BIT];
    end else if (pend_status_reg) begin
      aux_select_pointer_reg <= i_dmem_rdata[`DSPOAD_STAT_PTR];
    end
  end

  // Sequencer: only a port input occupies a second cycle.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (take && is_in) begin
          state_next = ST_IN2;
        end
      end
      ST_IN2: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // Issue stage: registered strobes are one-cycle pulses.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_RUN;
      o_dmem_addr <= 8'h00;
      o_dmem_rd <= 1'b0;
      o_dmem_wr <= 1'b0;
      o_dmem_wdata <= 16'h0000;
      o_port_rd <= 1'b0;
      o_port_addr <= 3'h0;
      o_tbl_rd <= 1'b0;
      o_tbl_wr <= 1'b0;
      o_shift_cnt <= 4'h0;
      o_shift_valid <= 1'b0;
      o_acc_load <= 1'b0;
      o_acc_value <= 32'h00000000;
      pend_page_reg <= 1'b0;
      pend_status_reg <= 1'b0;
      pend_aux_reg <= 2'b00;
      pend_mul_reg <= 1'b0;
      last_addr_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      o_dmem_rd <= 1'b0;
      o_dmem_wr <= 1'b0;
      o_port_rd <= 1'b0;
      o_tbl_rd <= 1'b0;
      o_tbl_wr <= 1'b0;
      o_shift_valid <= 1'b0;
      o_acc_load <= 1'b0;
      pend_page_reg <= take && is_page_mem;
      pend_status_reg <= take && is_status_ld;
      pend_aux_reg <= {take && is_aux_mem && opc[0], take && is_aux_mem && !opc[0]};
      pend_mul_reg <= take && is_mul_mem;
      if (state_reg[1]) begin
        // Second port input cycle: the port word goes into memory.
        o_dmem_wr <= 1'b1;
        o_dmem_wdata <= i_port_data;
      end else if (take && has_operand) begin
        o_dmem_addr <= operand_addr;
        last_addr_reg <= operand_addr;
        // store aux register
        // The forwarded value stores a load landing in this same cycle.
        if (is_aux_st) begin
          o_dmem_wr <= 1'b1;
          o_dmem_wdata <= opc[0] ? aux_eff[31:16] : aux_eff[15:0];
        end else if (is_in) begin
          o_port_rd <= 1'b1;
          o_port_addr <= opc[2:0];
        end else if (is_tab_rd) begin
          o_tbl_rd <= 1'b1;
        end else if (is_tab_wr) begin
          o_tbl_wr <= 1'b1;
        end else if (!is_modify) begin
          // Everything else reads its operand; modify touches no memory.
          o_dmem_rd <= 1'b1;
        end
        if (is_add) begin
          o_shift_cnt <= opc[3:0];
          o_shift_valid <= 1'b1;
        end
      end else if (take && is_acc_short) begin
        o_acc_load <= 1'b1;
        o_acc_value <= {24'h000000, i_instr[7:0]};
      end
    end
  end

  assign o_page_select_bit = page_select_bit_reg;
  assign o_aux_select_pointer = aux_select_pointer_reg;

  // Avalon slave: one wait state, then the answer with waitrequest low.
  assign avs_req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = avs_req && !ack_reg;

  // Read data is captured in the wait state so it stands at the answer.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_reg <= 1'b0;
      ctrl_en_reg <= `DSPOAD_CTRL_RST;
      o_avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= avs_req && !ack_reg;
      if (i_avs_write && ack_reg && i_avs_byteenable[0] &&
          i_avs_address == `DSPOAD_REG_CTRL) begin
        ctrl_en_reg <= i_avs_writedata[0];
      end
      if (i_avs_read && !ack_reg) begin
        case (i_avs_address)
          `DSPOAD_REG_CTRL: o_avs_readdata <= {31'h00000000, ctrl_en_reg};
          `DSPOAD_REG_STATUS: o_avs_readdata <= {29'h00000000, state_reg[1],
                                                 aux_select_pointer_reg, page_select_bit_reg};
          `DSPOAD_REG_AUX0: o_avs_readdata <= {16'h0000, aux_stored[15:0]};
          `DSPOAD_REG_AUX1: o_avs_readdata <= {16'h0000, aux_stored[31:16]};
          `DSPOAD_REG_LASTADDR: o_avs_readdata <= {24'h000000, last_addr_reg};
          // Unmapped words read as zero.
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // dspoad_decode

// ==== rtl/dspoad_mul.v ====
// Signed multiplier that fills the product register.
`timescale 1ns/10ps
module dspoad_mul (
  input wire i_core_clk,
  input wire i_arst_n,
  input wire i_start,
  input wire [15:0] i_operand,
  input wire [15:0] i_mult_in,
  output reg [31:0] o_product,
  output reg o_product_valid
);
  // Product register updates only when a multiply is issued.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_product <= 32'h00000000;
      o_product_valid <= 1'b0;
    end else begin
      o_product_valid <= i_start;
      if (i_start) begin
        o_product <= $signed(i_operand) * $signed(i_mult_in);
      end
    end
  end
endmodule // dspoad_mul
